/* File: logic/quad_uart_pins.sv */
// How it works
// (R1) data-set-ready shows in modem status and the modem interrupt status bit; never touches serial data.
// (R2) setting terminal-ready bit drives terminal-ready pin active low.
// (R3) terminal-ready pin high during reset and in loopback.
// (R4) clearing modem-control bit 0 returns terminal-ready pin high.
// (R5) mode pin low: channel interrupt pin enabled by its gate bit 3.
// (R6) gate bit clear floats interrupt pin; set drives it.
// (R7) mode pin high: interrupt pins always driven, gate bit ignored.
// (R8) interrupt pin high only for pending sources that are enabled.
// (R9) sources: rx error, rx data or timeout, tx empty, modem change.
// (R10) interrupt pin falls once serviced or on reset.
// (R11) read strobe returns the addressed register of the selected channel.
// (R12) write strobe loads data into addressed register of selected channel.
// (R13) reset clears channel registers and sets outputs to reset states.
// (R14) serial transmit and receive paths disabled while reset held.
// (R15) host picks a channel register with three address bits.
// (R16) host selects a channel with its own active-low select.
// (R17) driven interrupt pin with nothing pending stays low.
module quad_uart_pins (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // host register port
  input wire logic [uart_pins_pkg::NUM_CH-1:0] channel_select_n_i,
  input wire logic [uart_pins_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [uart_pins_pkg::DATA_W-1:0] write_data_i,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  output logic [uart_pins_pkg::DATA_W-1:0] read_data_o,
  output logic read_data_oe_o,
  // interrupt pins
  input wire logic irq_mode_select_i,
  output logic [uart_pins_pkg::NUM_CH-1:0] channel_irq_out_o,
  output logic [uart_pins_pkg::NUM_CH-1:0] channel_irq_oe_o,
  // modem pins
  input wire logic [uart_pins_pkg::NUM_CH-1:0] data_set_ready_in_n_i,
  output logic [uart_pins_pkg::NUM_CH-1:0] terminal_ready_out_n_o,
  // serial engine side
  input wire logic [uart_pins_pkg::NUM_CH-1:0][uart_pins_pkg::DATA_W-1:0] rx_byte_i,
  input wire logic [uart_pins_pkg::NUM_CH-1:0] rx_byte_valid_i,
  input wire logic [uart_pins_pkg::NUM_CH-1:0] rx_error_i,
  input wire logic [uart_pins_pkg::NUM_CH-1:0] rx_timeout_i,
  input wire logic [uart_pins_pkg::NUM_CH-1:0] thr_empty_i,
  input wire logic [uart_pins_pkg::NUM_CH-1:0] fifo_mode_i,
  output logic [uart_pins_pkg::NUM_CH-1:0][uart_pins_pkg::DATA_W-1:0] tx_byte_o,
  output logic [uart_pins_pkg::NUM_CH-1:0] tx_byte_valid_o,
  output logic [uart_pins_pkg::NUM_CH-1:0] loopback_o,
  output logic serial_path_en_o
);

  localparam int NCH = uart_pins_pkg::NUM_CH;
  localparam int DW = uart_pins_pkg::DATA_W;

  // a strobe reaches a channel only while its select is low as well
  function automatic logic strobe_hit(input logic strobe_n, input logic sel_n);
    return ~strobe_n & ~sel_n;
  endfunction : strobe_hit

  // lowest selected channel wins when the host selects several for a read
  function automatic logic [1:0] first_selected(input logic [NCH-1:0] sel_n);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (!sel_n[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction : first_selected

  // channel state
  uart_pins_pkg::modem_ctrl_t mctrl [NCH];
  uart_pins_pkg::modem_ctrl_t next_mctrl [NCH];
  uart_pins_pkg::irq_events_t irq_en [NCH];
  uart_pins_pkg::irq_events_t next_irq_en [NCH];
  uart_pins_pkg::irq_events_t irq_stat [NCH];
  uart_pins_pkg::irq_events_t next_irq_stat [NCH];
  logic [DW-1:0] rx_hold [NCH];
  logic [DW-1:0] next_rx_hold [NCH];
  logic [DW-1:0] scratch [NCH];
  logic [DW-1:0] next_scratch [NCH];
  logic [NCH-1:0] delta_dsr;
  logic [NCH-1:0] next_delta_dsr;
  logic [NCH-1:0] dsr_prev;
  logic [NCH-1:0] next_dsr_prev;
  logic [NCH-1:0][DW-1:0] next_tx_byte;
  logic [NCH-1:0] next_tx_valid;
  logic [NCH-1:0] next_term_n;
  logic [NCH-1:0] pending;
  logic run;

  // host read answer
  logic [DW-1:0] next_read_data;
  logic next_read_oe;

  // synchronised pins
  logic [NCH-1:0] dsr_n_sync;
  logic [NCH-1:0] dsr_active;
  logic mode_high;

  pin_sync #(
    .W(NCH),
    .RST_VAL({NCH{1'b1}})
  ) u_dsr_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(data_set_ready_in_n_i),
    .level_o(dsr_n_sync)
  );

  pin_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_mode_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(irq_mode_select_i),
    .level_o(mode_high)
  );

  // in loopback the status sees the channel's own terminal-ready bit
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      dsr_active[c] = mctrl[c].loopback ? mctrl[c].term_ready : ~dsr_n_sync[c];
    end
  end

  // register writes, events and status clears
  always_comb begin
    logic wr;
    logic rd;
    wr = 1'b0;
    rd = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      next_mctrl[c] = mctrl[c];
      next_irq_en[c] = irq_en[c];
      next_irq_stat[c] = irq_stat[c];
      next_rx_hold[c] = rx_hold[c];
      next_scratch[c] = scratch[c];
      next_delta_dsr[c] = delta_dsr[c];
      next_dsr_prev[c] = dsr_active[c];
      next_tx_byte[c] = tx_byte_o[c];
      next_tx_valid[c] = 1'b0;
      wr = strobe_hit(write_strobe_n_i, channel_select_n_i[c]); // [R12] [R16]
      rd = strobe_hit(read_strobe_n_i, channel_select_n_i[c]);
      if (wr) begin
        unique case (reg_addr_i) // [R15]
          uart_pins_pkg::REG_DATA: begin
            next_tx_byte[c] = write_data_i;
            next_tx_valid[c] = 1'b1;
          end
          uart_pins_pkg::REG_IRQ_EN: begin
            next_irq_en[c] = uart_pins_pkg::irq_events_t'(write_data_i[4:0]);
          end
          uart_pins_pkg::REG_IRQ_STAT: begin
            // servicing: write one to clear
            next_irq_stat[c] = irq_stat[c]
              & ~uart_pins_pkg::irq_events_t'(write_data_i[4:0]); // [R10]
          end
          uart_pins_pkg::REG_MODEM_CTRL: begin
            next_mctrl[c] = uart_pins_pkg::modem_ctrl_t'(write_data_i); // [R2] [R4]
          end
          uart_pins_pkg::REG_SCRATCH: begin
            next_scratch[c] = write_data_i;
          end
          default: begin
          end
        endcase
      end
      if (rd && reg_addr_i == uart_pins_pkg::REG_MODEM_STAT) begin
        next_delta_dsr[c] = 1'b0;
      end
      // events come after clears so a same-cycle event is kept
      if (rx_byte_valid_i[c]) begin
        next_rx_hold[c] = rx_byte_i[c];
        next_irq_stat[c].rx_data = 1'b1; // [R9]
      end
      if (rx_error_i[c]) begin
        next_irq_stat[c].rx_err = 1'b1; // [R9]
      end
      if (rx_timeout_i[c] && fifo_mode_i[c]) begin
        next_irq_stat[c].timeout = 1'b1; // [R9]
      end
      if (thr_empty_i[c]) begin
        next_irq_stat[c].thr_empty = 1'b1; // [R9]
      end
      if (dsr_active[c] != dsr_prev[c]) begin
        next_delta_dsr[c] = 1'b1; // [R1]
        next_irq_stat[c].modem = 1'b1; // [R9]
      end
      next_term_n[c] = ~(next_mctrl[c].term_ready & ~next_mctrl[c].loopback); // [R2] [R3]
    end
  end

  // read mux; data stand in the cycle after the strobe
  always_comb begin
    logic [1:0] ch;
    ch = first_selected(channel_select_n_i);
    next_read_oe = ~read_strobe_n_i & ~&channel_select_n_i; // [R11]
    next_read_data = uart_pins_pkg::DATA_RST;
    if (next_read_oe) begin
      unique case (reg_addr_i)
        uart_pins_pkg::REG_DATA: next_read_data = rx_hold[ch];
        uart_pins_pkg::REG_IRQ_EN: next_read_data = {3'h0, irq_en[ch]};
        uart_pins_pkg::REG_IRQ_STAT: next_read_data = {3'h0, irq_stat[ch]};
        uart_pins_pkg::REG_MODEM_CTRL: next_read_data = mctrl[ch];
        uart_pins_pkg::REG_MODEM_STAT: begin
          next_read_data[uart_pins_pkg::MS_DSR_BIT] = dsr_active[ch]; // [R1]
          next_read_data[uart_pins_pkg::MS_DELTA_DSR_BIT] = delta_dsr[ch];
        end
        uart_pins_pkg::REG_SCRATCH: next_read_data = scratch[ch];
        default: next_read_data = uart_pins_pkg::DATA_RST;
      endcase
    end
  end

  // channel registers; a reset wipes every channel at once
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        mctrl[c] <= uart_pins_pkg::MODEM_CTRL_RST; // [R13]
        irq_en[c] <= uart_pins_pkg::IRQ_EN_RST;
        irq_stat[c] <= uart_pins_pkg::IRQ_STAT_RST;
        rx_hold[c] <= uart_pins_pkg::DATA_RST;
        scratch[c] <= uart_pins_pkg::DATA_RST;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        mctrl[c] <= next_mctrl[c];
        irq_en[c] <= next_irq_en[c];
        irq_stat[c] <= next_irq_stat[c];
        rx_hold[c] <= next_rx_hold[c];
        scratch[c] <= next_scratch[c];
      end
    end
  end

  // prev resets to the idle level, so no false change follows reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      delta_dsr <= '0;
      dsr_prev <= '0;
    end else begin
      delta_dsr <= next_delta_dsr;
      dsr_prev <= next_dsr_prev;
    end
  end

  // serial engine side; run lags reset by one cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCH; c++) begin
        tx_byte_o[c] <= uart_pins_pkg::DATA_RST;
      end
      tx_byte_valid_o <= '0;
      run <= 1'b0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        tx_byte_o[c] <= next_tx_byte[c];
      end
      tx_byte_valid_o <= next_tx_valid;
      run <= 1'b1;
    end
  end

  // terminal-ready pins, inactive high from reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      terminal_ready_out_n_o <= '1; // [R3]
    end else begin
      terminal_ready_out_n_o <= next_term_n;
    end
  end

  // host read answer; stands as long as the strobe is held, one cycle late
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      read_data_o <= uart_pins_pkg::DATA_RST;
      read_data_oe_o <= 1'b0;
    end else begin
      read_data_o <= next_read_data;
      read_data_oe_o <= next_read_oe;
    end
  end

  // the serial engine is held off for the whole reset
  assign serial_path_en_o = run & ~rst_i; // [R14]

  // a pending source needs both its status and its enable bit
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      pending[c] = |(irq_stat[c] & irq_en[c]); // [R8]
      loopback_o[c] = mctrl[c].loopback;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_irq
    irq_pin_drive u_irq (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .mode_high_i(mode_high),
      .irq_gate_bit_i(mctrl[g].irq_gate_bit),
      .pending_i(pending[g]),
      .irq_o(channel_irq_out_o[g]),
      .irq_oe_o(channel_irq_oe_o[g])
    );
  end

endmodule : quad_uart_pins

/* File: logic/uart_pins_pkg.sv */
package uart_pins_pkg;

  localparam int NUM_CH = 4;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NUM_EV = 5;
  localparam int SYNC_STAGES = 3;

  // register offsets within one channel
  localparam logic [ADDR_W-1:0] REG_DATA = 3'h0;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN = 3'h1;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 3'h2;
  localparam logic [ADDR_W-1:0] REG_MODEM_CTRL = 3'h4;
  localparam logic [ADDR_W-1:0] REG_MODEM_STAT = 3'h6;
  localparam logic [ADDR_W-1:0] REG_SCRATCH = 3'h7;

  // modem status field positions
  localparam int MS_DELTA_DSR_BIT = 1;
  localparam int MS_DSR_BIT = 5;

  // reset values
  localparam logic [DATA_W-1:0] MODEM_CTRL_RST = 8'h00;
  localparam logic [NUM_EV-1:0] IRQ_EN_RST = 5'h00;
  localparam logic [NUM_EV-1:0] IRQ_STAT_RST = 5'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // modem control: bit 0 terminal ready, bit 3 irq gate, bit 4 loopback
  typedef struct packed {
    logic [2:0] spare_hi;
    logic loopback;
    logic irq_gate_bit;
    logic [1:0] spare_lo;
    logic term_ready;
  } modem_ctrl_t;

  // interrupt events, same layout in status and enable registers
  typedef struct packed {
    logic timeout;
    logic modem;
    logic thr_empty;
    logic rx_data;
    logic rx_err;
  } irq_events_t;

endpackage : uart_pins_pkg

/* File: logic/pin_sync.sv */
// three-stage synchroniser; output moves only when stages two and three agree
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // pins
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_level;

  always_comb begin
    next_level = level_o;
    for (int i = 0; i < W; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      level_o <= RST_VAL;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      level_o <= next_level;
    end
  end

endmodule : pin_sync

/* File: logic/irq_pin_drive.sv */
// one channel's three-state interrupt pin
module irq_pin_drive (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // control
  input wire logic mode_high_i,
  input wire logic irq_gate_bit_i,
  input wire logic pending_i,
  // pin
  output logic irq_o,
  output logic irq_oe_o
);

  logic next_irq;
  logic next_oe;

  always_comb begin
    next_irq = pending_i; // [R8] [R17]
    next_oe = mode_high_i | irq_gate_bit_i; // [R5] [R6] [R7]
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0; // [R10]
      irq_oe_o <= 1'b0;
    end else begin
      irq_o <= next_irq;
      irq_oe_o <= next_oe;
    end
  end

endmodule : irq_pin_drive

/* File: bench/quad_uart_pins_monitor.sv */
module quad_uart_pins_monitor (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // host port
  input wire logic [3:0] channel_select_n_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] write_data_i,
  input wire logic write_strobe_n_i,
  input wire logic read_strobe_n_i,
  input wire logic read_data_oe_o,
  // pins
  input wire logic irq_mode_select_i,
  input wire logic [3:0] channel_irq_out_o,
  input wire logic [3:0] channel_irq_oe_o,
  input wire logic [3:0] terminal_ready_out_n_o,
  input wire logic [3:0] loopback_o,
  input wire logic serial_path_en_o,
  // events
  input wire logic [3:0] rx_byte_valid_i,
  input wire logic [3:0] rx_error_i,
  input wire logic [3:0] rx_timeout_i,
  input wire logic [3:0] thr_empty_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr0;
  logic mc0;
  logic ev0;
  logic rd_any;
  assign wr0 = !write_strobe_n_i && !channel_select_n_i[0];
  assign mc0 = wr0 && reg_addr_i == uart_pins_pkg::REG_MODEM_CTRL;
  assign ev0 = rx_byte_valid_i[0] | rx_error_i[0] | rx_timeout_i[0] | thr_empty_i[0];
  assign rd_any = !read_strobe_n_i && !(&channel_select_n_i);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // event inputs must stay quiet, or a late event would set status again
  sequence s_clear0;
    wr0 && reg_addr_i == uart_pins_pkg::REG_IRQ_STAT && write_data_i == 8'h1f && !ev0 ##1 !ev0;
  endsequence
  sequence s_mode_low;
    !irq_mode_select_i [*8];
  endsequence
  AST_RST_PINS: assert property (
    $fell(rst_i) |-> &terminal_ready_out_n_o && channel_irq_out_o == 4'h0 && channel_irq_oe_o == 4'h0)
    else $error("pins not in reset state");
  AST_SERIAL_OFF: assert property (
    $fell(rst_i) |-> !serial_path_en_o ##3 serial_path_en_o) else $error("serial path enable wrong");
  AST_DTR_BIT: assert property (
    mc0 && !write_data_i[4] |-> ##2 terminal_ready_out_n_o[0] == !$past(write_data_i[0], 2))
    else $error("terminal ready pin does not follow bit 0");
  AST_DTR_LOOP: assert property (
    mc0 && write_data_i[4] |-> ##2 terminal_ready_out_n_o[0] && loopback_o[0])
    else $error("terminal ready active in loopback");
  AST_GATE: assert property (
    s_mode_low ##0 mc0 |-> ##2 channel_irq_oe_o[0] == $past(write_data_i[3], 2))
    else $error("irq enable does not follow gate bit");
  AST_MODE_HIGH: assert property (
    irq_mode_select_i [*8] |-> &channel_irq_oe_o) else $error("irq pins not driven in mode high");
  AST_IRQ_RISE: assert property (
    $rose(channel_irq_out_o[0]) |-> $past(ev0, 2) || $past(wr0, 2))
    else $error("irq rose without cause");
  AST_IRQ_CLEAR: assert property (
    s_clear0 |=> !channel_irq_out_o[0]) else $error("irq stays high after service");
  AST_READ_OE: assert property (
    read_data_oe_o == $past(rd_any)) else $error("read data enable wrong");
endmodule : quad_uart_pins_monitor

/* File: bench/modem_model.sv */
module modem_model #(
  parameter int DELAY = 2
) (
  // clock
  input wire logic sys_clk_i,
  // bench control
  input wire logic [3:0] dsr_req_i,
  // pins
  output logic [3:0] data_set_ready_in_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a slow data set: ready answers some cycles after it is asked for
  logic [3:0] pipe [DELAY] = '{default: 4'hf};
  always @(posedge sys_clk_i) begin
    pipe[0] <= ~dsr_req_i;
    for (int i = 1; i < DELAY; i++) pipe[i] <= pipe[i-1];
  end
  assign data_set_ready_in_n_o = pipe[DELAY-1];
endmodule : modem_model

/* File: bench/quad_uart_pins_tb.sv */
module quad_uart_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] MC = uart_pins_pkg::REG_MODEM_CTRL;
  localparam logic [2:0] IEN = uart_pins_pkg::REG_IRQ_EN;
  localparam logic [2:0] IST = uart_pins_pkg::REG_IRQ_STAT;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] channel_select_n_i = 4'hf;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] write_data_i = 8'h00;
  logic write_strobe_n_i = 1'b1;
  logic read_strobe_n_i = 1'b1;
  logic irq_mode_select_i = 1'b0;
  logic [3:0][7:0] rx_byte_i = {4{8'ha5}};
  logic [3:0] rx_byte_valid_i = '0, rx_error_i = '0, rx_timeout_i = '0, thr_empty_i = '0;
  logic [3:0] fifo_mode_i = 4'h1, dsr_req = '0, dsr_n;
  logic [7:0] read_data_o;
  logic read_data_oe_o, serial_path_en_o, tx_seen = 1'b0;
  logic [3:0] channel_irq_out_o, channel_irq_oe_o, terminal_ready_out_n_o, tx_byte_valid_o;
  logic [3:0] loopback_o;
  logic [3:0][7:0] tx_byte_o;
  int mismatches = 0;
  int check_count = 0;

  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) if (tx_byte_valid_o !== 4'h0) tx_seen <= 1'b1;

  quad_uart_pins dut_u (.sys_clk_i, .rst_i, .channel_select_n_i, .reg_addr_i, .write_data_i,
    .write_strobe_n_i, .read_strobe_n_i, .read_data_o, .read_data_oe_o, .irq_mode_select_i,
    .channel_irq_out_o, .channel_irq_oe_o, .data_set_ready_in_n_i(dsr_n),
    .terminal_ready_out_n_o, .rx_byte_i, .rx_byte_valid_i, .rx_error_i, .rx_timeout_i,
    .thr_empty_i, .fifo_mode_i, .tx_byte_o, .tx_byte_valid_o, .loopback_o, .serial_path_en_o);
  modem_model #(.DELAY(3)) modem_u (.sys_clk_i, .dsr_req_i(dsr_req), .data_set_ready_in_n_o(dsr_n));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [3:0] sel, input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    channel_select_n_i <= sel;
    reg_addr_i <= a;
    write_data_i <= d;
    write_strobe_n_i <= 1'b0;
    @(posedge sys_clk_i);
    channel_select_n_i <= 4'hf;
    write_strobe_n_i <= 1'b1;
  endtask : wr

  task automatic rd(input logic [3:0] sel, input logic [2:0] a, output logic [7:0] v,
                    output logic o);
    @(posedge sys_clk_i);
    channel_select_n_i <= sel;
    reg_addr_i <= a;
    read_strobe_n_i <= 1'b0;
    @(posedge sys_clk_i);
    channel_select_n_i <= 4'hf;
    read_strobe_n_i <= 1'b1;
    #1;
    v = read_data_o;
    o = read_data_oe_o;
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : settle

  task automatic ev(input int s);
    @(posedge sys_clk_i);
    case (s)
      0: rx_error_i <= 4'h1;
      1: rx_byte_valid_i <= 4'h1;
      2: thr_empty_i <= 4'h1;
      3: dsr_req <= 4'h1;
      default: rx_timeout_i <= 4'h1;
    endcase
    @(posedge sys_clk_i);
    {rx_error_i, rx_byte_valid_i, thr_empty_i, rx_timeout_i} <= '0;
    settle(12);
  endtask : ev

  task automatic t_regs();
    logic [7:0] v;
    logic o;
    for (int c = 0; c < 4; c++) wr(~(4'h1 << c), uart_pins_pkg::REG_SCRATCH, 8'h30 + 8'(c));
    for (int c = 0; c < 4; c++) begin
      rd(~(4'h1 << c), uart_pins_pkg::REG_SCRATCH, v, o);
      chk(v, 8'h30 + 8'(c));
      chk({7'h0, o}, 8'h01);
    end
    rd(4'he, 3'h3, v, o);
    chk(v, 8'h00);
    rd(4'hf, uart_pins_pkg::REG_SCRATCH, v, o);
    chk({7'h0, o}, 8'h00);
  endtask : t_regs

  task automatic t_dtr();
    logic [7:0] mc [5] = '{8'h01, 8'h11, 8'h01, 8'h00, 8'h01};
    logic [3:0] pin [5] = '{4'he, 4'hf, 4'he, 4'hf, 4'hb};
    for (int i = 0; i < 5; i++) begin
      wr(i < 4 ? 4'he : 4'hb, MC, mc[i]);
      settle(2);
      chk(8'(terminal_ready_out_n_o), 8'(pin[i]));
    end
    wr(4'hb, MC, 8'h00);
  endtask : t_dtr

  task automatic t_irq();
    logic [7:0] v;
    logic o;
    wr(4'he, MC, 8'h08);
    settle(2);
    chk(8'(channel_irq_oe_o), 8'h01);
    // loopback toggling before left a modem event pending
    wr(4'he, IST, 8'h1f);
    for (int s = 0; s < 5; s++) begin
      wr(4'he, IEN, 8'h00);
      ev(s);
      chk(8'(channel_irq_out_o), 8'h00);
      rd(4'he, IST, v, o);
      chk(v, 8'h01 << s);
      wr(4'he, IEN, 8'h01 << s);
      settle(2);
      chk(8'(channel_irq_out_o), 8'h01);
      wr(4'he, IST, 8'h1f);
      settle(2);
      chk(8'(channel_irq_out_o), 8'h00);
    end
    rd(4'he, uart_pins_pkg::REG_MODEM_STAT, v, o);
    chk(v & 8'h22, 8'h22);
    chk({7'h0, tx_seen}, 8'h00);
    @(posedge sys_clk_i);
    irq_mode_select_i <= 1'b1;
    settle(8);
    chk(8'(channel_irq_oe_o), 8'h0f);
    @(posedge sys_clk_i);
    irq_mode_select_i <= 1'b0;
  endtask : t_irq

  task automatic t_data();
    logic [7:0] v;
    logic o;
    rd(4'he, uart_pins_pkg::REG_DATA, v, o);
    chk(v, 8'ha5);
    wr(4'hd, uart_pins_pkg::REG_DATA, 8'h5a);
    #1;
    chk(8'(tx_byte_valid_o), 8'h02);
    chk(tx_byte_o[1], 8'h5a);
    @(posedge sys_clk_i);
    rx_timeout_i <= 4'h2;
    @(posedge sys_clk_i);
    rx_timeout_i <= 4'h0;
    settle(2);
    rd(4'hd, IST, v, o);
    chk(v, 8'h00);
  endtask : t_data

  task automatic t_reset();
    wr(4'he, MC, 8'h09);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    settle(2);
    chk(8'(terminal_ready_out_n_o), 8'h0f);
    chk(8'(channel_irq_oe_o), 8'h00);
    chk(8'(serial_path_en_o), 8'h00);
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    settle(4);
    chk(8'(serial_path_en_o), 8'h01);
  endtask : t_reset

  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    t_regs();
    t_dtr();
    t_irq();
    t_data();
    t_reset();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    complete_run();
  end
endmodule : quad_uart_pins_tb

bind quad_uart_pins quad_uart_pins_monitor mon_u (.sys_clk_i, .rst_i, .channel_select_n_i,
  .reg_addr_i, .write_data_i, .write_strobe_n_i, .read_strobe_n_i, .read_data_oe_o,
  .irq_mode_select_i, .channel_irq_out_o, .channel_irq_oe_o, .terminal_ready_out_n_o,
  .loopback_o, .serial_path_en_o, .rx_byte_valid_i, .rx_error_i, .rx_timeout_i, .thr_empty_i);
